// *** design/smio_pkg.sv ***
// shared types and constants for the multi-lane serial interface pin-role block
package smio_pkg;
   typedef enum logic [1:0] {
      SMIO_W1,
      SMIO_W2,
      SMIO_W4
   } smio_width_t;

   // lane pin bundle, one bit per shared pin
   typedef struct packed {
      logic [3:0] val;
   } smio_lanes_t;

   localparam int          SMIO_SYNC_STAGES = 2;
   localparam int          SMIO_FIFO_DEPTH  = 8;
   localparam int          SMIO_FIFO_WIDTH  = 4;
   localparam logic [3:0]  SMIO_LANES_RST   = 4'h0;
   localparam logic [3:0]  SMIO_PINS_IDLE   = 4'hF;
   localparam int          SMIO_LANE_ZERO   = 0;
   localparam int          SMIO_LANE_ONE    = 1;
   localparam int          SMIO_LANE_TWO    = 2;
   localparam int          SMIO_LANE_THREE  = 3;
endpackage : smio_pkg

// *** design/smio_fifo.sv ***
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module smio_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      count_ff;
   logic             push;
   logic             pop;
   logic [AW:0]      nxt_count;
   logic             in_ready_ff;
   logic             out_valid_ff;

   // flags held in flops, so valid and ready leave straight from registers
   assign in_ready  = in_ready_ff;
   assign out_valid = out_valid_ff;
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid && in_ready_ff;
   assign pop       = out_valid_ff && out_ready;
   assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || flush) begin
         wr_ptr_ff    <= '0;
         rd_ptr_ff    <= '0;
         count_ff     <= '0;
         in_ready_ff  <= 1'b1;
         out_valid_ff <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff     <= nxt_count;
         in_ready_ff  <= (nxt_count != (AW+1)'(DEPTH));
         out_valid_ff <= (nxt_count != '0);
      end
   end
endmodule : smio_fifo

// *** design/smio_pin_roles.sv ***
// pin-role selection and lane shifting for the multi-lane serial interface
//
// What this block does
// - single-lane transfers plus dual and quad transfers over shared lanes.
// - pin zero is serial input in single mode, lane zero in dual/quad.
// - pin one is serial output in single mode, lane one in dual/quad.
// - pin two is active-low write protect unless quad enabled, then lane two.
// - pin three low pauses single/dual transfers; lane three in quad mode.
// - reset select set: pin three is active-low reset unless quad and selected.
// - sample inputs on rising serial clock; change outputs after falling edge.
// - chip select high: ignore data and hold inputs, float outputs; low starts each command.
// - pause entry and exit take effect only while serial clock is low.
// - quad enable bit disables hold and write protect for lanes three, two.
`timescale 1ns/10ps
module smio_pin_roles
   import smio_pkg::*;
#(
   parameter int FIFO_WIDTH = SMIO_FIFO_WIDTH,
   parameter int FIFO_DEPTH = SMIO_FIFO_DEPTH
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  sck,
   input  wire logic                  cs_n,
   input  wire logic [3:0]            lane_in,
   output logic      [3:0]            lane_out,
   output logic      [3:0]            lane_oe,
   input  wire logic                  quad_enable_bit,
   input  wire logic                  reset_pin_select_bit,
   input  wire smio_width_t           xfer_width,
   input  wire logic                  drive_dir,
   output logic      [FIFO_WIDTH-1:0] rx_data,
   output logic                       rx_valid,
   input  wire logic                  rx_ready,
   input  wire logic [FIFO_WIDTH-1:0] tx_data,
   input  wire logic                  tx_valid,
   output logic                       tx_ready,
   output logic                       write_protect_ff,
   output logic                       hw_reset_ff,
   output logic                       hold_ff,
   output logic                       selected_ff
);
   logic [1:0] sck_sync_ff;
   logic [1:0] cs_sync_ff;
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic       sck_d_ff;
   logic       sck_rise;
   logic       sck_fall;
   logic       sck_low;
   logic       sel;
   logic       hold_pin_ok;
   logic       nxt_hold;
   logic [3:0] nxt_oe;
   logic [3:0] nxt_out;
   logic [3:0] rx_sample;
   logic       rx_push;
   logic       tx_pop;
   logic [FIFO_WIDTH-1:0] tx_word;
   logic       tx_word_valid;
   logic [3:0] lane_out_ff;
   logic [3:0] lane_oe_ff;

   // lanes used per width, decoded at several places
   function automatic logic [3:0] lane_mask(input smio_width_t w);
      case (w)
         SMIO_W1: lane_mask = 4'h1;
         SMIO_W2: lane_mask = 4'h3;
         SMIO_W4: lane_mask = 4'hF;
         default: lane_mask = 4'h1;
      endcase
   endfunction : lane_mask

   // two-flop synchronisers for every pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sck_sync_ff <= 2'h0;
         cs_sync_ff  <= 2'h3;
         pin_s1_ff   <= SMIO_PINS_IDLE;
         pin_s2_ff   <= SMIO_PINS_IDLE;
      end else begin
         sck_sync_ff <= {sck_sync_ff[0], sck};
         cs_sync_ff  <= {cs_sync_ff[0], cs_n};
         pin_s1_ff   <= lane_in;
         pin_s2_ff   <= pin_s1_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sck_d_ff <= 1'b0;
      end else begin
         sck_d_ff <= sck_sync_ff[1];
      end
   end

   assign sck_rise = sck_sync_ff[1] && !sck_d_ff;
   assign sck_fall = !sck_sync_ff[1] && sck_d_ff;
   assign sck_low  = !sck_sync_ff[1];
   assign sel      = !cs_sync_ff[1];

   // hold pin is only a pause in non-quad mode with reset select clear
   assign hold_pin_ok = !quad_enable_bit && !reset_pin_select_bit;

   always_comb begin
      nxt_hold = hold_ff;
      if (!sel || !hold_pin_ok || xfer_width == SMIO_W4) begin
         nxt_hold = 1'b0;
      end else if (sck_low) begin
         nxt_hold = !pin_s2_ff[SMIO_LANE_THREE];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_ff <= 1'b0;
      end else begin
         hold_ff <= nxt_hold;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         selected_ff <= 1'b0;
      end else begin
         selected_ff <= sel;
      end
   end

   // write protect, active low, only outside quad mode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         write_protect_ff <= 1'b0;
      end else begin
         write_protect_ff <= !quad_enable_bit && !pin_s2_ff[SMIO_LANE_TWO];
      end
   end

   // hardware reset role of pin three
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hw_reset_ff <= 1'b0;
      end else begin
         hw_reset_ff <= reset_pin_select_bit && (!quad_enable_bit || !sel)
                        && !pin_s2_ff[SMIO_LANE_THREE];
      end
   end

   // receive: sample lanes on rising clock edge
   always_comb begin
      rx_sample = 4'h0;
      case (xfer_width)
         SMIO_W1: rx_sample = {3'h0, pin_s2_ff[SMIO_LANE_ZERO]};
         SMIO_W2: rx_sample = {2'h0, pin_s2_ff[1:0]};
         SMIO_W4: rx_sample = quad_enable_bit ? pin_s2_ff : {2'h0, pin_s2_ff[1:0]};
         default: rx_sample = 4'h0;
      endcase
   end

   assign rx_push = sel && !hold_ff && !drive_dir && sck_rise;

   smio_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .flush    (1'b0),
      .in_data  (FIFO_WIDTH'(rx_sample)),
      .in_valid (rx_push),
      .in_ready (),
      .out_data (rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   smio_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .flush    (!sel),
      .in_data  (tx_data),
      .in_valid (tx_valid),
      .in_ready (tx_ready),
      .out_data (tx_word),
      .out_valid(tx_word_valid),
      .out_ready(tx_pop)
   );

   // transmit: shift next symbol out after falling clock edge
   assign tx_pop = sel && !hold_ff && drive_dir && sck_fall;

   always_comb begin
      nxt_oe  = 4'h0;
      nxt_out = lane_out_ff;
      if (sel && !hold_ff && drive_dir) begin
         case (xfer_width)
            SMIO_W1: nxt_oe = 4'h2;
            SMIO_W2: nxt_oe = lane_mask(SMIO_W2);
            SMIO_W4: nxt_oe = quad_enable_bit ? lane_mask(SMIO_W4) : 4'h0;
            default: nxt_oe = 4'h0;
         endcase
         // an empty queue leaves the lanes at their last symbol
         if (tx_pop && tx_word_valid) begin
            if (xfer_width == SMIO_W1) begin
               nxt_out = {2'h0, tx_word[0], 1'b0};
            end else begin
               nxt_out = 4'(tx_word) & lane_mask(xfer_width);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lane_out_ff <= SMIO_LANES_RST;
         lane_oe_ff  <= SMIO_LANES_RST;
      end else begin
         lane_out_ff <= nxt_out;
         lane_oe_ff  <= nxt_oe;
      end
   end

   assign lane_out = lane_out_ff;
   assign lane_oe  = lane_oe_ff;
endmodule : smio_pin_roles

// *** verification/smio_pin_roles_assertions.sv ***
// port-level checks of the pin-role block
`timescale 1ns/10ps
module smio_pin_roles_assertions
   import smio_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic [3:0]  lane_in,
   input wire logic [3:0]  lane_oe,
   input wire logic        quad_enable_bit,
   input wire logic        reset_pin_select_bit,
   input wire smio_width_t xfer_width,
   input wire logic        drive_dir,
   input wire logic        write_protect_ff,
   input wire logic        hw_reset_ff,
   input wire logic        hold_ff
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   AST_FLOAT: assert property (cs_n [*6] |-> lane_oe == 4'h0)
      else $error("lanes driven while deselected");
   AST_IDLE_HOLD: assert property (cs_n [*5] |-> !hold_ff)
      else $error("hold kept while deselected");
   AST_HOLD_FLOAT: assert property (hold_ff [*2] |-> lane_oe == 4'h0)
      else $error("lanes driven in hold");
   AST_RX_FLOAT: assert property ((!drive_dir) [*5] |-> lane_oe == 4'h0)
      else $error("lanes driven while receiving");
   AST_SINGLE_PINS: assert property ((xfer_width == SMIO_W1) [*5] |-> (lane_oe & 4'hD) == 4'h0)
      else $error("wrong pin driven in single mode");
   AST_NO_QUAD: assert property ((!quad_enable_bit) [*5] |-> lane_oe[3:2] == 2'h0)
      else $error("upper lanes driven without quad");
   AST_WP_SET: assert property ((!lane_in[2] && !quad_enable_bit) [*5] |-> write_protect_ff)
      else $error("write protect missed");
   AST_QUAD_PINS: assert property (quad_enable_bit [*5] |-> !write_protect_ff && !hold_ff)
      else $error("protect or hold active in quad");
   AST_RST_SET: assert property ((!lane_in[3] && reset_pin_select_bit && !quad_enable_bit) [*5]
      |-> hw_reset_ff) else $error("pin reset missed");
   AST_RST_OFF: assert property ((!reset_pin_select_bit) [*5] |-> !hw_reset_ff)
      else $error("pin reset without select");
   AST_RST_QUAD: assert property ((quad_enable_bit && !cs_n) [*5] |-> !hw_reset_ff)
      else $error("pin reset during quad transfer");
endmodule : smio_pin_roles_assertions

// *** verification/smio_host.sv ***
// host controller model: serial clock, select and host-driven lanes
`timescale 1ns/10ps
module smio_host (
   output logic       sck,
   output logic       cs_n,
   output logic [3:0] host_val,
   output logic [3:0] host_oe
);
   initial begin
      sck = 1'b0;
      set(1'b1, 4'h0, 4'h0);
   end
   task automatic set(input logic c, input logic [3:0] o, input logic [3:0] v);
      cs_n = c;
      host_oe = o;
      host_val = v;
   endtask : set
   // clock stands still outside frames
   task automatic frame(input int n, input logic [3:0] o);
      set(1'b0, o, 4'($urandom));
      repeat (n) begin
         #62.5 sck = 1'b1;
         #62.5 sck = 1'b0;
         host_val = 4'($urandom);
      end
      #62.5 set(1'b1, 4'h0, 4'h0);
      #250;
   endtask : frame
endmodule : smio_host

// *** verification/testbench.sv ***
// self-checking bench of the pin-role block against the host model
`timescale 1ns/10ps
`define CHK(n, g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
   import smio_pkg::*;
   logic        sys_clk, rst, sck, cs_n, quad_enable_bit, reset_pin_select_bit, drive_dir, c;
   logic        rx_valid, rx_ready, tx_valid, tx_ready, selected_ff, hold_ff;
   logic        write_protect_ff, hw_reset_ff;
   logic [2:0]  e;
   logic [3:0]  lane_in, lane_out, lane_oe, host_val, host_oe, rx_data, tx_data, w;
   logic [3:0]  q[$], tq[$];
   logic [5:0]  fl[5] = '{6'h05, 6'h10, 6'h0E, 6'h18, 6'h3A};
   smio_width_t xfer_width;
   int          failures, samples_checked, k;
   smio_host hst (.*);
   smio_pin_roles uut (.*);
   assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_oe & host_val)
                  | (~lane_oe & ~host_oe & {2'b11, ~host_val[1:0]});
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   function automatic logic [3:0] lanes(input logic tx);
      case (xfer_width)
         SMIO_W1: return tx ? 4'h2 : 4'h1;
         SMIO_W2: return 4'h3;
         default: return quad_enable_bit ? 4'hF : (tx ? 4'h0 : 4'h3);
      endcase
   endfunction : lanes
   always @(posedge sck) begin
      k++;
      if (!drive_dir && q.size() < SMIO_FIFO_DEPTH) q.push_back(lane_in & lanes(1'b0));
      if (drive_dir && k > 1 && tq.size() > 0) begin
         w = tq.pop_front();
         `CHK("lane_oe", lane_oe, lanes(1'b1))
         `CHK("lanes", lane_in & lanes(1'b1), xfer_width == SMIO_W1 ? {2'b00, w[0], 1'b0} : w & lanes(1'b1))
      end
   end
   task automatic drain();
      logic [3:0] exp_word;
      repeat (12) begin
         @(negedge sys_clk);
         rx_ready = rx_valid;
         if (rx_valid === 1'b1) begin
            exp_word = q.pop_front();
            `CHK("rx_data", rx_data, exp_word)
         end
      end
      rx_ready = 1'b0;
      `CHK("rx_left", q.size(), 0)
      `CHK("rx_empty", rx_valid, 1'b0)
   endtask : drain
   task automatic fill();
      wait (selected_ff === 1'b1);
      repeat (10) begin
         @(negedge sys_clk);
         tx_valid = tx_ready;
         tx_data = 4'($urandom);
         if (tx_ready === 1'b1) tq.push_back(tx_data);
      end
      tx_valid = 1'b0;
      `CHK("tx_fill", tq.size(), SMIO_FIFO_DEPTH)
   endtask : fill
   task automatic wrap_up();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h615A78FE));
      {rst, quad_enable_bit, reset_pin_select_bit, drive_dir, rx_ready, tx_valid} = 6'h20;
      tx_data = 4'h0;
      xfer_width = SMIO_W1;
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      for (int i = 0; i < 6; i++) begin
         @(negedge sys_clk);
         xfer_width = smio_width_t'(i % 3);
         quad_enable_bit = (i >= 3);
         reset_pin_select_bit = 1'($urandom);
         drive_dir = 1'b0;
         k = 0;
         hst.frame(10, lanes(1'b0));
         drain();
         drive_dir = 1'b1;
         k = 0;
         fork
            hst.frame(9, 4'h0);
            fill();
         join
         `CHK("tx_left", tq.size(), 0)
         tq.delete();
      end
      xfer_width = SMIO_W1;
      for (int i = 0; i < 5; i++) begin
         @(negedge sys_clk);
         {c, quad_enable_bit, reset_pin_select_bit, e} = fl[i];
         hst.set(c, 4'hC, 4'h0);
         repeat (8) @(negedge sys_clk);
         `CHK("flags", {write_protect_ff, hw_reset_ff, hold_ff}, e)
         `CHK("selected", selected_ff, !c)
      end
      wrap_up();
   end
endmodule : testbench
bind smio_pin_roles smio_pin_roles_assertions u_chk (.*);
